// [hdl/clock_select_params.svh]
// Offsets, field positions, reset values and bus answers of the clock selector
// Assumes an AXI4-Lite slave with 8-bit byte addresses and 32-bit data
`ifndef CLOCK_SELECT_PARAMS_SVH
`define CLOCK_SELECT_PARAMS_SVH

// Register byte offsets
`define CS_PANEL_OFS 8'h00
`define CS_MONITOR_OFS 8'h04
`define CS_MEMORY_OFS 8'h08
`define CS_CAMERA_OFS 8'h0c
`define CS_STATUS_OFS 8'h10

// Field positions in a clock control word
`define CS_SRC_LSB 0
`define CS_DIV_LSB 4
// Status word: active configs in bytes 0..3, strap ratio at this bit
`define CS_RATIO_BIT 31

// Reset values: source code in [1:0], divide code in [5:4]
`define CS_PIXEL_SRC_RST 2'h0
`define CS_MEMORY_SRC_RST 2'h1
`define CS_DIV_RST 2'h0

// Bus responses
`define CS_RESP_OKAY 2'h0
`define CS_RESP_SLVERR 2'h2

`endif

// [hdl/clock_select_pkg.sv]
// Types shared by the clock selector
// Assumes clock_select_params.svh for all numeric constants
package clock_select_pkg;

	// Selection and divide code of one derived clock
	typedef struct packed {
		logic [1:0] div;
		logic [1:0] src;
	} clk_cfg_t;

	// Synchronised pins: strap, host bus, third, second, primary
	typedef logic [4:0] pin_vec_t;

	// Channel numbers
	typedef enum logic [1:0] {
		chan_panel,
		chan_monitor,
		chan_memory,
		chan_camera
	} chan_t;

endpackage : clock_select_pkg

// [hdl/pixel_memory_clock_select.sv]
// Clock selection and division for panel, monitor, memory and camera clocks
// Assumes clock pins slower than core_clk / 2; outputs are core_clk-registered levels
// Contract
// - Strap fixes internal bus ratio at reset
// - Panel pixel source: primary, second, host, memory
// - Panel source passes a programmable divider
// - Monitor pixel source chosen independently, same choices
// - Monitor source divided by own divisor
// - Memory source: primary, third, host; divided
// - Camera clock from selectable source, own divider
// - Pixel divider offers four ratios
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`include "clock_select_params.svh"

module pixel_memory_clock_select (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Clock pins and strap
	input wire logic primary_clock_input,
	input wire logic second_clock_input,
	input wire logic third_clock_input,
	input wire logic host_bus_clock,
	input wire logic bus_ratio_strap,
	// Derived clocks
	output logic internal_bus_clock,
	output logic panel_pixel_clock,
	output logic monitor_pixel_clock,
	output logic memory_clock,
	output logic camera_port_clock,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// Register index from byte address; 3'h7 means unmapped
	function automatic logic [2:0] reg_index(input logic [7:0] addr);
		case (addr)
			`CS_PANEL_OFS: reg_index = 3'h0;
			`CS_MONITOR_OFS: reg_index = 3'h1;
			`CS_MEMORY_OFS: reg_index = 3'h2;
			`CS_CAMERA_OFS: reg_index = 3'h3;
			`CS_STATUS_OFS: reg_index = 3'h4;
			default: reg_index = 3'h7;
		endcase
	endfunction : reg_index

	// Source level of one channel; lv is {memory, host, third, second, primary}
	function automatic logic pick(input logic [1:0] ch, input logic [1:0] sel, input logic [4:0] lv);
		if (ch == 2'(clock_select_pkg::chan_memory)) begin
			case (sel)
				2'h1: pick = lv[2];
				2'h2: pick = lv[3];
				default: pick = lv[0];
			endcase
		end else begin
			case (sel)
				2'h0: pick = lv[0];
				2'h1: pick = lv[1];
				2'h2: pick = lv[3];
				default: pick = lv[4];
			endcase
		end
	endfunction : pick

	// Source edges in the high phase: ratio div+1, high while count < (div+2)/2
	function automatic logic high_phase(input logic [1:0] cnt, input logic [1:0] div);
		high_phase = {1'b0, cnt} < (3'({1'b0, div}) + 3'h2) >> 1;
	endfunction : high_phase
	clock_select_pkg::pin_vec_t pin_s1_r;
	clock_select_pkg::pin_vec_t pin_s2_r;
	logic [3:0] pin_prev_r;
	logic mem_prev_r;
	logic strap_done_r;
	logic ratio_half_r;
	logic bus_clk_r;
	clock_select_pkg::clk_cfg_t cfg_r [4];
	clock_select_pkg::clk_cfg_t act_r [4];
	logic [1:0] cnt_r [4];
	logic [3:0] out_r;
	logic [4:0] cur_lv;
	logic [4:0] prev_lv;
	logic [3:0] lvl;
	logic [3:0] rise;
	logic [3:0] swap;
	logic aw_got_r;
	logic w_got_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wstrb0_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [2:0] wr_idx;
	logic [2:0] rd_idx;

	// Pin synchronisers; no reset, so the strap is settled when reset ends
	always_ff @(posedge core_clk) begin
		pin_s1_r <= {bus_ratio_strap, host_bus_clock, third_clock_input, second_clock_input, primary_clock_input};
		pin_s2_r <= pin_s1_r;
		pin_prev_r <= pin_s2_r[3:0];
	end

	// Strap caught once after reset release, then frozen
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			strap_done_r <= 1'b0;
			ratio_half_r <= 1'b0;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			ratio_half_r <= pin_s2_r[4];
		end
	end

	// Internal bus clock: follows host clock or toggles on its rising edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bus_clk_r <= 1'b0;
		end else if (!ratio_half_r) begin
			bus_clk_r <= pin_s2_r[3];
		end else if (pin_s2_r[3] && !pin_prev_r[3]) begin
			bus_clk_r <= !bus_clk_r;
		end
	end

	// Source selection and edge detection per channel
	always_comb begin
		cur_lv = {out_r[2], pin_s2_r[3:0]};
		prev_lv = {mem_prev_r, pin_prev_r};
		for (int i = 0; i < 4; i++) begin
			lvl[i] = pick(2'(i), act_r[i].src, cur_lv);
			rise[i] = lvl[i] && !pick(2'(i), act_r[i].src, prev_lv);
			swap[i] = (cfg_r[i] != act_r[i]) && !out_r[i] &&
				(act_r[i].div == 2'h0 || (rise[i] && cnt_r[i] == act_r[i].div));
		end
	end

	// Dividers; a new selection takes over only while the output is low, at the end of a low phase when dividing
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				act_r[i] <= (i == 2) ? {`CS_DIV_RST, `CS_MEMORY_SRC_RST} : {`CS_DIV_RST, `CS_PIXEL_SRC_RST};
				cnt_r[i] <= 2'h0;
			end
			out_r <= 4'h0;
			mem_prev_r <= 1'b0;
		end else begin
			mem_prev_r <= out_r[2];
			for (int i = 0; i < 4; i++) begin
				if (swap[i]) begin
					act_r[i] <= cfg_r[i];
					cnt_r[i] <= 2'h0;
					out_r[i] <= 1'b0;
				end else if (act_r[i].div == 2'h0) begin
					out_r[i] <= lvl[i];
				end else if (rise[i]) begin
					cnt_r[i] <= (cnt_r[i] == act_r[i].div) ? 2'h0 : cnt_r[i] + 2'h1;
					out_r[i] <= high_phase((cnt_r[i] == act_r[i].div) ? 2'h0 : cnt_r[i] + 2'h1, act_r[i].div);
				end
			end
		end
	end

	assign internal_bus_clock = bus_clk_r;
	assign panel_pixel_clock = out_r[0];
	assign monitor_pixel_clock = out_r[1];
	assign memory_clock = out_r[2];
	assign camera_port_clock = out_r[3];

	// AXI4-Lite write channel
	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign wr_idx = reg_index(awaddr_r);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `CS_RESP_OKAY;
			for (int i = 0; i < 4; i++) begin
				cfg_r[i] <= (i == 2) ? {`CS_DIV_RST, `CS_MEMORY_SRC_RST} : {`CS_DIV_RST, `CS_PIXEL_SRC_RST};
			end
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb0_r <= s_axi_wstrb[0];
			end
			if (aw_got_r && w_got_r) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (wr_idx == 3'h7) ? `CS_RESP_SLVERR : `CS_RESP_OKAY;
				if (wr_idx < 3'h4 && wstrb0_r) begin
					cfg_r[wr_idx[1:0]] <= {wdata_r[`CS_DIV_LSB +: 2], wdata_r[`CS_SRC_LSB +: 2]};
				end
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign rd_idx = reg_index(s_axi_araddr);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `CS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r <= (rd_idx == 3'h7) ? `CS_RESP_SLVERR : `CS_RESP_OKAY;
			if (rd_idx < 3'h4) begin
				rdata_r <= {26'h0, cfg_r[rd_idx[1:0]].div, 2'h0, cfg_r[rd_idx[1:0]].src};
			end else if (rd_idx == 3'h4) begin
				rdata_r <= {ratio_half_r, 3'h0, act_r[3], 4'h0, act_r[2], 4'h0, act_r[1], 4'h0, act_r[0]};
			end else begin
				rdata_r <= 32'h0000_0000;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_strap_frozen: assert property (strap_done_r |=> $stable(ratio_half_r))
		else $error("bus ratio changed after reset");
	a_bus_halving: assert property (ratio_half_r && pin_s2_r[3] && !pin_prev_r[3] |=>
		internal_bus_clock != $past(internal_bus_clock))
		else $error("halved bus clock missed a toggle");
	a_panel_follow: assert property (act_r[0].div == 2'h0 && !swap[0] |=> panel_pixel_clock == $past(lvl[0]))
		else $error("panel clock does not follow its source");
	a_panel_count: assert property (rise[0] && !swap[0] && act_r[0].div != 2'h0 && cnt_r[0] != act_r[0].div |=>
		cnt_r[0] == 2'($past(cnt_r[0]) + 2'h1))
		else $error("panel divider did not advance");
	a_monitor_follow: assert property (act_r[1].div == 2'h0 && !swap[1] |=> monitor_pixel_clock == $past(lvl[1]))
		else $error("monitor clock does not follow its source");
	a_monitor_wrap: assert property (rise[1] && act_r[1].div != 2'h0 && cnt_r[1] == act_r[1].div |=>
		cnt_r[1] == 2'h0)
		else $error("monitor divider did not wrap");
	a_memory_third: assert property (act_r[2].src == 2'h1 |-> lvl[2] == pin_s2_r[2])
		else $error("memory source is not the third input");
	a_camera_count: assert property (rise[3] && !swap[3] && act_r[3].div != 2'h0 && cnt_r[3] != act_r[3].div |=>
		cnt_r[3] == 2'($past(cnt_r[3]) + 2'h1))
		else $error("camera divider did not advance");
	a_count_range: assert property (cnt_r[0] <= act_r[0].div && cnt_r[1] <= act_r[1].div)
		else $error("pixel divider count out of range");
	a_switch_low: assert property (act_r[0] != $past(act_r[0]) |-> !$past(panel_pixel_clock) && !panel_pixel_clock)
		else $error("panel source switched during a high phase");
	a_reset_default: assert property (!strap_done_r |-> act_r[2] == {`CS_DIV_RST, `CS_MEMORY_SRC_RST} &&
		act_r[0] == {`CS_DIV_RST, `CS_PIXEL_SRC_RST} && act_r[1] == {`CS_DIV_RST, `CS_PIXEL_SRC_RST})
		else $error("derived clocks not at defaults after reset");
	c_panel_switch: cover property (swap[0]);
	c_bus_halved: cover property (ratio_half_r && internal_bus_clock);
	c_monitor_div4: cover property (act_r[1].div == 2'h3 && rise[1] && cnt_r[1] == 2'h3);
	c_write_error: cover property (s_axi_bvalid && s_axi_bresp == `CS_RESP_SLVERR);

endmodule : pixel_memory_clock_select

// [tb/clock_sources.sv]
// Free-running oscillators and host bus clock for the clock selector
// Assumes core_clk of 100 ns; edges fall on core_clk falling edges
`timescale 1ns/100ps

module clock_sources (
	// Clock pins, all below 5 MHz (core_clk / 2)
	output logic primary,
	output logic second,
	output logic third,
	output logic host
);
	initial begin
		primary = 1'b0;
		forever #200 primary = ~primary;
	end
	initial begin
		second = 1'b0;
		forever #300 second = ~second;
	end
	initial begin
		third = 1'b0;
		forever #400 third = ~third;
	end
	initial begin
		host = 1'b0;
		forever #500 host = ~host;
	end
endmodule : clock_sources

// [tb/testbench.sv]
// Self-checking bench for the clock selector: bus tasks, period meter, model
// Assumes clock_sources on the pins and the design's parameter header
`timescale 1ns/100ps
`include "clock_select_params.svh"

module testbench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic strap = 1'b0;
	logic pri, sec, thi, hst, ibc, pnl, mon, mem, cam;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [4:0] outs;
	int n_fail = 0;
	int n_checks = 0;
	int seed = 32'h14af25e8;
	int msrc[4];
	int mdiv[4];

	assign outs = {ibc, cam, mem, mon, pnl};
	always #50 core_clk = ~core_clk;

	clock_sources osc (.primary(pri), .second(sec), .third(thi), .host(hst));

	pixel_memory_clock_select uut (.core_clk(core_clk), .rst(rst),
		.primary_clock_input(pri), .second_clock_input(sec), .third_clock_input(thi),
		.host_bus_clock(hst), .bus_ratio_strap(strap), .internal_bus_clock(ibc),
		.panel_pixel_clock(pnl), .monitor_pixel_clock(mon), .memory_clock(mem), .camera_port_clock(cam),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic ah, wh, bh;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bh = 1'b0;
		while (!bh) begin
			@(negedge core_clk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bready && bvalid;
			if (bh) chk("bresp", 32'(er), 32'(bresp));
			@(posedge core_clk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ah, rh;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rh = 1'b0;
		while (!rh) begin
			@(negedge core_clk);
			ah = arvalid && arready;
			rh = rready && rvalid;
			if (rh) chk("rdata", ed, rdata);
			if (rh) chk("rresp", 32'(er), 32'(rresp));
			@(posedge core_clk);
			if (ah) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask : rd

	// Period of one output in core cycles, second rise to third
	task automatic per(input int ch, input int ep);
		int k, r1, n;
		logic pv;
		r1 = 0;
		n = 0;
		pv = 1'b1;
		for (k = 0; k < 1200 && n < 3; k++) begin
			@(negedge core_clk);
			if (!pv && outs[ch]) begin
				n++;
				if (n == 3) chk("period", 32'(ep), 32'(k - r1));
				r1 = k;
			end
			pv = outs[ch];
		end
		if (n < 3) chk("period", 32'(ep), 32'h0);
	endtask : per

	// Source period of a channel in core cycles
	function automatic int sp(input int ch, input int s);
		int t[4];
		if (ch == 2) t = '{4, 8, 10, 4};
		else t = '{4, 6, 10, (mdiv[2] + 1) * sp(2, msrc[2])};
		return t[s];
	endfunction : sp

	function automatic logic [31:0] st();
		logic [31:0] v;
		v = {strap, 31'h0};
		for (int i = 0; i < 4; i++) v[i * 8 +: 4] = 4'(mdiv[i] * 4 + msrc[i]);
		return v;
	endfunction : st

	task automatic cfg(input int ch, input int s, input int d);
		msrc[ch] = s;
		mdiv[ch] = d;
		wr(8'(ch * 4), 32'(d * 16 + s), 4'hf, `CS_RESP_OKAY);
		rd(8'(ch * 4), 32'(d * 16 + s), `CS_RESP_OKAY);
		per(ch, (d + 1) * sp(ch, s));
	endtask : cfg

	task automatic do_reset(input logic s);
		@(posedge core_clk);
		strap <= s;
		rst <= 1'b1;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		chk("reset outs", 32'h0, 32'(outs));
		@(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			msrc[i] = (i == 2) ? 1 : 0;
			mdiv[i] = 0;
		end
	endtask : do_reset

	initial begin
		do_reset(1'b0);
		for (int i = 0; i < 4; i++) rd(8'(i * 4), (i == 2) ? 32'h1 : 32'h0, `CS_RESP_OKAY);
		rd(`CS_STATUS_OFS, st(), `CS_RESP_OKAY);
		per(4, 10);
		$display("reset test done");
		wr(8'h14, 32'h33, 4'hf, `CS_RESP_SLVERR);
		rd(8'h14, 32'h0, `CS_RESP_SLVERR);
		wr(`CS_STATUS_OFS, 32'hffffffff, 4'hf, `CS_RESP_OKAY);
		wr(`CS_PANEL_OFS, 32'h33, 4'he, `CS_RESP_OKAY);
		rd(`CS_PANEL_OFS, 32'h0, `CS_RESP_OKAY);
		rd(`CS_STATUS_OFS, st(), `CS_RESP_OKAY);
		$display("bus test done");
		for (int c = 0; c < 4; c++)
			for (int s = 0; s < 4; s++) cfg(c, s, (c == 2) ? 0 : ($random(seed) & 3));
		rd(`CS_STATUS_OFS, st(), `CS_RESP_OKAY);
		$display("sweep test done");
		for (int d = 0; d < 4; d++) cfg(0, 0, d);
		$display("divider test done");
		do_reset(1'b1);
		rd(`CS_STATUS_OFS, st(), `CS_RESP_OKAY);
		per(4, 20);
		$display("strap test done");
		stop_test();
	end

	initial begin
		#(20000 * 100);
		n_fail++;
		stop_test();
	end
endmodule : testbench
